// File: design/usart_core.sv
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module usart_core
    import usart_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave.
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial pins.
    output logic shift_clock_line_out,
    output logic shift_clock_line_oe,
    input wire logic serial_data_line_in,
    output logic serial_data_line_out,
    output logic serial_data_line_oe,
    // Interrupt request and the receive interrupt's priority.
    output logic irq,
    output logic rx_irq_priority
);
    logic [7:0] gic;
    logic [7:0] enable_bank;
    logic [7:0] priority_bank;
    logic [7:0] rx_ctl;
    logic [7:0] tx_ctl;
    logic [7:0] baud_divisor;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_buffer_empty_flag;
    logic [3:0] tx_buffer_empty_flag_cnt;
    logic transmit_enable_q;
    logic rx_complete_flag;
    logic [7:0] rx_buf;
    logic rx_ninth;
    logic framing_error;
    logic overrun_error;
    logic din_meta;
    logic din;
    logic [7:0] div_cnt;
    rx_state_t rx_state;
    logic [5:0] samp_cnt;
    logic [3:0] rx_bits;
    logic [8:0] rx_shift;
    tx_state_t tx_state;
    logic [3:0] load_cnt;
    logic [1:0] phase;
    logic [3:0] tx_bits;
    logic [8:0] shifter;

    // Register port decode; effects land once per transfer.
    wire req = read | write;
    wire capture = req & waitrequest;
    wire accept = write & ~waitrequest & byteenable[0];
    wire [7:0] wd = writedata[7:0];
    wire wr_gic = accept & (address == ADDR_GLOBAL_IRQ);
    wire wr_enable = accept & (address == ADDR_ENABLE_BANK);
    wire wr_priority = accept & (address == ADDR_PRIORITY_BANK);
    wire wr_rx_ctl = accept & (address == ADDR_RX_STATUS);
    wire wr_tx_ctl = accept & (address == ADDR_TX_STATUS);
    wire wr_txbuf = accept & (address == ADDR_TX_DATA);
    wire wr_baud = accept & (address == ADDR_BAUD);
    wire rd_rxbuf = capture & read & (address == ADDR_RX_DATA);

    wire port_en = rx_ctl[PORT_EN_BIT];
    wire rx9 = rx_ctl[RX9_BIT];
    wire single_receive_enable = rx_ctl[SINGLE_RECEIVE_ENABLE_BIT];
    wire continuous_receive_enable = rx_ctl[CONTINUOUS_RECEIVE_ENABLE_BIT];
    wire address_detect_enable = rx_ctl[ADDRESS_DETECT_ENABLE_BIT];
    wire clock_source_master_select = tx_ctl[CLOCK_SOURCE_MASTER_SELECT_BIT];
    wire tx9 = tx_ctl[TX9_BIT];
    wire transmit_enable = tx_ctl[TRANSMIT_ENABLE_BIT];
    wire sync = tx_ctl[SYNC_BIT];
    wire high_rate_select = tx_ctl[HIGH_RATE_SELECT_BIT];
    wire transmit_ninth_bit = tx_ctl[NINTH_BIT];
    wire shifter_empty_status = (tx_state != TX_SHIFT);

    wire [7:0] flag_rd = {2'b00, rx_complete_flag, tx_buffer_empty_flag, 4'h0};
    wire [7:0] rx_rd = {rx_ctl[7:3], framing_error, overrun_error, rx_ninth};
    wire [7:0] tx_rd = {tx_ctl[7:4], 1'b0, high_rate_select, shifter_empty_status, transmit_ninth_bit};
    wire [7:0] rd_value =
        (address == ADDR_GLOBAL_IRQ) ? {gic[GIE_BIT], 7'h00} :
        (address == ADDR_FLAG_BANK) ? flag_rd :
        (address == ADDR_ENABLE_BANK) ? enable_bank :
        (address == ADDR_PRIORITY_BANK) ? priority_bank :
        (address == ADDR_RX_STATUS) ? rx_rd :
        (address == ADDR_RX_DATA) ? rx_buf :
        (address == ADDR_TX_STATUS) ? tx_rd :
        (address == ADDR_TX_DATA) ? tx_buf :
        (address == ADDR_BAUD) ? baud_divisor : 8'h00;

    // One waitrequest-high cycle per access; readdata is captured with it.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            waitrequest <= ~capture;
            if (capture & read)
                readdata <= {24'h000000, rd_value};
        end
    end

    // Software-written control registers; the shifter has no address.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            gic <= ZERO_RESET;
            enable_bank <= ZERO_RESET;
            priority_bank <= PRIORITY_RESET;
            rx_ctl <= ZERO_RESET;
            tx_ctl <= ZERO_RESET;
            baud_divisor <= ZERO_RESET;
            tx_buf <= ZERO_RESET;
        end
        else
        begin
            if (wr_gic)
                gic <= wd;
            if (wr_enable)
                enable_bank <= wd;
            if (wr_priority)
                priority_bank <= wd;
            if (wr_rx_ctl)
                rx_ctl <= {wd[7:3], 3'b000};
            if (wr_tx_ctl)
                tx_ctl <= {wd[7:4], 1'b0, wd[HIGH_RATE_SELECT_BIT], 1'b0, wd[NINTH_BIT]};
            if (wr_baud)
                baud_divisor <= wd;
            if (wr_txbuf)
                tx_buf <= wd;
        end
    end

    // Two flops on the data pin before anything looks at it.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            din_meta <= 1'b1;
            din <= 1'b1;
        end
        else
        begin
            din_meta <= serial_data_line_in;
            din <= din_meta;
        end
    end

    // Shared baud generator: one tick every divisor plus one clocks.
    wire baud_tick = (div_cnt == baud_divisor);
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            div_cnt <= 8'h00;
        else
            div_cnt <= baud_tick ? 8'h00 : div_cnt + 8'h01;
    end

    // Asynchronous receiver, sampled mid-bit at 16x or 64x the bit rate.
    wire rx_en = port_en & ~sync & continuous_receive_enable & ~overrun_error;
    wire [5:0] samp_last = high_rate_select ? OVS_HIGH_LAST : OVS_LOW_LAST;
    wire [5:0] samp_mid = high_rate_select ? OVS_HIGH_MID : OVS_LOW_MID;
    wire [3:0] rx_nbits = rx9 ? 4'h9 : 4'h8;
    wire samp_end = baud_tick & (samp_cnt == samp_last);
    wire frame_done = (rx_state == RX_STOP) & samp_end;
    wire [7:0] rx_byte = rx9 ? rx_shift[7:0] : rx_shift[8:1];
    wire rx_bit9 = rx9 & rx_shift[8];
    wire addr_drop = address_detect_enable & rx9 & ~rx_bit9;
    wire rx_take = frame_done & ~addr_drop;

    always_ff @(posedge clk)
    begin
        if (!rst_b | !rx_en)
        begin
            rx_state <= RX_IDLE;
            samp_cnt <= 6'h00;
            rx_bits <= 4'h0;
            rx_shift <= 9'h000;
        end
        else
        begin
            if (baud_tick)
                samp_cnt <= (rx_state == RX_IDLE) | samp_end ? 6'h00 : samp_cnt + 6'h01;
            unique case (rx_state)
                RX_IDLE:
                    if (!din)
                        rx_state <= RX_START;
                RX_START:
                    if (baud_tick & (samp_cnt == samp_mid))
                    begin
                        rx_state <= din ? RX_IDLE : RX_DATA;
                        samp_cnt <= 6'h00;
                        rx_bits <= 4'h0;
                    end
                RX_DATA:
                    if (samp_end)
                    begin
                        rx_shift <= {din, rx_shift[8:1]};
                        rx_bits <= rx_bits + 4'h1;
                        if (rx_bits + 4'h1 == rx_nbits)
                            rx_state <= RX_STOP;
                    end
                RX_STOP:
                    if (samp_end)
                        rx_state <= RX_IDLE;
            endcase
        end
    end

    // Receive buffer, flag and errors; a new word beats a same-cycle read.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rx_complete_flag <= 1'b0;
            rx_buf <= 8'h00;
            rx_ninth <= 1'b0;
            framing_error <= 1'b0;
            overrun_error <= 1'b0;
        end
        else
        begin
            if (rd_rxbuf)
                rx_complete_flag <= 1'b0;
            if (rx_take & rx_complete_flag & ~rd_rxbuf)
                overrun_error <= 1'b1;
            else if (rx_take)
            begin
                rx_complete_flag <= 1'b1;
                rx_buf <= rx_byte;
                rx_ninth <= rx_bit9;
                framing_error <= ~din;
            end
            if (!continuous_receive_enable)
            begin
                framing_error <= 1'b0;
                overrun_error <= 1'b0;
            end
        end
    end

    // Synchronous master transmitter; held off while a receive is enabled.
    wire tx_go = port_en & sync & clock_source_master_select & transmit_enable & ~(single_receive_enable | continuous_receive_enable);
    wire [3:0] tx_nbits = tx9 ? 4'h9 : 4'h8;
    wire bit_end = baud_tick & (phase == SYNC_PHASE_LAST);
    wire last_bit = bit_end & (tx_bits + 4'h1 == tx_nbits);
    wire load_done = (tx_state == TX_LOAD) & (load_cnt == 4'h0);

    always_ff @(posedge clk)
    begin
        if (!rst_b | !tx_go)
        begin
            tx_state <= TX_IDLE;
            load_cnt <= 4'h0;
            phase <= 2'b00;
            tx_bits <= 4'h0;
            shifter <= 9'h000;
        end
        else
        begin
            unique case (tx_state)
                TX_IDLE:
                    if (tx_full)
                    begin
                        tx_state <= TX_LOAD;
                        load_cnt <= LOAD_LAST;
                    end
                TX_LOAD:
                    if (load_done)
                    begin
                        tx_state <= TX_SHIFT;
                        shifter <= {transmit_ninth_bit, tx_buf};
                        phase <= 2'b00;
                        tx_bits <= 4'h0;
                    end
                    else
                        load_cnt <= load_cnt - 4'h1;
                TX_SHIFT:
                begin
                    if (baud_tick)
                        phase <= phase + 2'b01;
                    if (bit_end)
                    begin
                        shifter <= {1'b0, shifter[8:1]};
                        tx_bits <= tx_bits + 4'h1;
                    end
                    if (last_bit)
                    begin
                        tx_state <= tx_full ? TX_LOAD : TX_IDLE;
                        load_cnt <= LOAD_LAST;
                    end
                end
                default:
                    tx_state <= TX_IDLE;
            endcase
        end
    end

    // The flag follows the buffer, with its clear held back two instruction cycles.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tx_full <= 1'b0;
            tx_buffer_empty_flag <= 1'b0;
            tx_buffer_empty_flag_cnt <= 4'h0;
            transmit_enable_q <= 1'b0;
        end
        else
        begin
            transmit_enable_q <= transmit_enable;
            if (wr_txbuf)
                tx_full <= 1'b1;
            else if (load_done & tx_go)
                tx_full <= 1'b0;
            if (wr_txbuf)
                tx_buffer_empty_flag_cnt <= TX_BUFFER_EMPTY_FLAG_DELAY;
            else if (tx_buffer_empty_flag_cnt != 4'h0)
                tx_buffer_empty_flag_cnt <= tx_buffer_empty_flag_cnt - 4'h1;
            if ((transmit_enable & ~transmit_enable_q) | (load_done & tx_go))
                tx_buffer_empty_flag <= 1'b1;
            else if (tx_buffer_empty_flag_cnt == 4'h1)
                tx_buffer_empty_flag <= ~tx_full;
        end
    end

    // Pins and interrupt request, all registered.
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            shift_clock_line_out <= 1'b0;
            shift_clock_line_oe <= 1'b0;
            serial_data_line_out <= 1'b1;
            serial_data_line_oe <= 1'b0;
            irq <= 1'b0;
            rx_irq_priority <= 1'b1;
        end
        else
        begin
            shift_clock_line_out <= (tx_state == TX_SHIFT) & phase[1];
            shift_clock_line_oe <= port_en & sync & clock_source_master_select;
            serial_data_line_out <= (tx_state == TX_SHIFT) ? shifter[0] : 1'b1;
            serial_data_line_oe <= tx_go;
            irq <= gic[GIE_BIT] & ((rx_complete_flag & enable_bank[RX_FLAG_BIT])
                | (tx_buffer_empty_flag & enable_bank[TX_FLAG_BIT]));
            rx_irq_priority <= priority_bank[RX_FLAG_BIT];
        end
    end

    a_irq_gating: assert property (@(posedge clk) disable iff (!rst_b)
        irq |-> $past(gic[GIE_BIT]) && ($past(rx_complete_flag && enable_bank[RX_FLAG_BIT])
            || $past(tx_buffer_empty_flag && enable_bank[TX_FLAG_BIT])))
        else $error("irq raised without an enabled flag");
    a_rx_word_flagged: assert property (@(posedge clk) disable iff (!rst_b)
        rx_take && !rx_complete_flag |=> rx_complete_flag && rx_buf == $past(rx_byte))
        else $error("accepted word not loaded");
    a_addr_filter: assert property (@(posedge clk) disable iff (!rst_b)
        frame_done && addr_drop |=> $stable(rx_buf) && $stable(rx_ninth))
        else $error("data frame loaded during address detect");
    a_overrun_set: assert property (@(posedge clk) disable iff (!rst_b)
        rx_take && rx_complete_flag && !rd_rxbuf && continuous_receive_enable |=> overrun_error)
        else $error("overrun not reported");
    a_err_clear: assert property (@(posedge clk) disable iff (!rst_b)
        !continuous_receive_enable |=> !framing_error && !overrun_error)
        else $error("errors survive receive disable");
    a_half_duplex: assert property (@(posedge clk) disable iff (!rst_b)
        tx_state != TX_IDLE |-> rx_state == RX_IDLE)
        else $error("transmit and receive overlap");
    a_load_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(tx_state == TX_LOAD) && tx_go |-> (tx_state == TX_LOAD)[*4]
            ##1 (tx_state == TX_SHIFT || !tx_go))
        else $error("buffer transfer not one instruction cycle");
    a_tx_buffer_empty_flag_delay: assert property (@(posedge clk) disable iff (!rst_b)
        wr_txbuf && tx_buffer_empty_flag |=> tx_buffer_empty_flag[*7])
        else $error("transmit flag cleared early");
    a_transmit_enable_sets: assert property (@(posedge clk) disable iff (!rst_b)
        transmit_enable && !transmit_enable_q |=> tx_buffer_empty_flag)
        else $error("transmit enable did not set flag");
    a_lsb_first: assert property (@(posedge clk) disable iff (!rst_b)
        load_done && tx_go |=> ##1 serial_data_line_out == $past(tx_buf[0], 2))
        else $error("first bit out is not bit zero");
    a_reload_wait: assert property (@(posedge clk) disable iff (!rst_b)
        tx_state == TX_SHIFT && !last_bit && tx_go |=> tx_state == TX_SHIFT)
        else $error("shifter reloaded before last bit");

    c_addr_frame: cover property (@(posedge clk) disable iff (!rst_b)
        frame_done && address_detect_enable && rx_take);
    c_overrun: cover property (@(posedge clk) disable iff (!rst_b) $rose(overrun_error));
    c_back_to_back: cover property (@(posedge clk) disable iff (!rst_b)
        last_bit && tx_full && tx_go);
    c_tx_buffer_empty_flag_cleared: cover property (@(posedge clk) disable iff (!rst_b) $fell(tx_buffer_empty_flag));
endmodule

// File: design/usart_pkg.sv
package usart_pkg;
    // Byte addresses of the word-aligned registers on the Avalon-MM port.
    localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'h00;
    localparam logic [7:0] ADDR_FLAG_BANK = 8'h04;
    localparam logic [7:0] ADDR_ENABLE_BANK = 8'h08;
    localparam logic [7:0] ADDR_PRIORITY_BANK = 8'h0C;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RX_DATA = 8'h14;
    localparam logic [7:0] ADDR_TX_STATUS = 8'h18;
    localparam logic [7:0] ADDR_TX_DATA = 8'h1C;
    localparam logic [7:0] ADDR_BAUD = 8'h20;
    // Field positions.
    localparam int GIE_BIT = 7;
    localparam int RX_FLAG_BIT = 5;
    localparam int TX_FLAG_BIT = 4;
    localparam int PORT_EN_BIT = 7;
    localparam int RX9_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
    localparam int FRAMING_ERROR_BIT = 2;
    localparam int OVERRUN_ERROR_BIT = 1;
    localparam int NINTH_BIT = 0;
    localparam int CLOCK_SOURCE_MASTER_SELECT_BIT = 7;
    localparam int TX9_BIT = 6;
    localparam int TRANSMIT_ENABLE_BIT = 5;
    localparam int SYNC_BIT = 4;
    localparam int HIGH_RATE_SELECT_BIT = 2;
    localparam int SHIFTER_EMPTY_STATUS_BIT = 1;
    // Values after reset.
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] PRIORITY_RESET = 8'hFF;
    localparam logic [7:0] TX_STATUS_RESET = 8'h02;
    // Timing: one instruction cycle is four core clocks.
    localparam int CLK_PERIOD_NS = 8;
    localparam int INSTR_CYCLE_NS = 32;
    localparam int INSTR_CYCLE_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int TX_BUFFER_EMPTY_FLAG_VALID_CYCLES = 2;
    localparam logic [3:0] LOAD_LAST = 4'(INSTR_CYCLE_CLKS - 1);
    localparam logic [3:0] TX_BUFFER_EMPTY_FLAG_DELAY = 4'(TX_BUFFER_EMPTY_FLAG_VALID_CYCLES * INSTR_CYCLE_CLKS);
    // Oversampling: last sample index and mid-bit index per bit time.
    localparam logic [5:0] OVS_HIGH_LAST = 6'h0F;
    localparam logic [5:0] OVS_HIGH_MID = 6'h07;
    localparam logic [5:0] OVS_LOW_LAST = 6'h3F;
    localparam logic [5:0] OVS_LOW_MID = 6'h1F;
    localparam logic [1:0] SYNC_PHASE_LAST = 2'h3;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01,
                              RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LOAD = 2'b01,
                              TX_SHIFT = 2'b10} tx_state_t;
endpackage

// File: test/serial_node.sv
`timescale 1ns/1ps
module serial_node
(
    // Device serial pins.
    input wire logic shift_clock_line_out,
    input wire logic shift_clock_line_oe,
    input wire logic serial_data_line_out,
    input wire logic serial_data_line_oe,
    // Level seen on the shared data wire.
    output logic serial_data_line_in
);
    parameter int BIT_NS = 640;
    logic drive = 1'b1;
    logic bits[$];
    // The idle bus rests high on its pull-up; the device wins while it drives.
    assign serial_data_line_in = serial_data_line_oe ? serial_data_line_out : drive;
    // A clocked bit is taken mid-bit, on the rising clock edge.
    always @(posedge shift_clock_line_out)
        if (shift_clock_line_oe)
            bits.push_back(serial_data_line_out);
    // Start bit, data least significant first, then the given stop level.
    task automatic send(input logic [8:0] d, input int n, input logic stop);
        drive = 1'b0;
        #BIT_NS;
        for (int i = 0; i < n; i++)
        begin
            drive = d[i];
            #BIT_NS;
        end
        drive = stop;
        #BIT_NS;
        drive = 1'b1;
        #(2 * BIT_NS);
    endtask
endmodule

// File: test/usart_core_tb.sv
`timescale 1ns/1ps
module usart_core_tb
    import usart_pkg::*;
;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1;} row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] readdata;
    logic [31:0] q;
    logic waitrequest, sck, sck_oe, sdi, sdo, sdo_oe, irq, rx_irq_priority;
    int n_fail = 0;
    int n_tests = 0;
    // A divisor of 4 gives a 160 ns shift clock and a 640 ns asynchronous bit.
    row_t rows [9] = '{
        '{ADDR_GLOBAL_IRQ, 8'hFF, 8'h00, 8'h80},
        '{ADDR_FLAG_BANK, 8'hFF, 8'h00, 8'h00},
        '{ADDR_ENABLE_BANK, 8'hFF, 8'h00, 8'hFF},
        '{ADDR_PRIORITY_BANK, 8'h00, 8'hFF, 8'h00},
        '{ADDR_RX_STATUS, 8'h07, 8'h00, 8'h00},
        '{ADDR_RX_DATA, 8'hFF, 8'h00, 8'h00},
        '{ADDR_TX_STATUS, 8'h0D, 8'h02, 8'h07},
        '{ADDR_BAUD, 8'h04, 8'h00, 8'h04},
        '{8'h24, 8'hFF, 8'h00, 8'h00}
    };
    usart_core i_usart_core (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .shift_clock_line_out(sck), .shift_clock_line_oe(sck_oe),
        .serial_data_line_in(sdi), .serial_data_line_out(sdo), .serial_data_line_oe(sdo_oe),
        .irq(irq), .rx_irq_priority(rx_irq_priority));
    serial_node i_serial_node (.shift_clock_line_out(sck), .shift_clock_line_oe(sck_oe),
        .serial_data_line_out(sdo), .serial_data_line_oe(sdo_oe), .serial_data_line_in(sdi));
    always #4 clk = ~clk;
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic fail_stop;
        n_fail++;
        report_and_stop();
    endtask
    // Waitrequest and read data are taken at the rising edge, before that edge's updates land.
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
        input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clk);
        address <= a;
        read <= ~w;
        write <= w;
        writedata <= {24'h0, d};
        byteenable <= be;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 200);
        if (k == 200)
            fail_stop();
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h00, 4'h1);
        check(q, {24'h0, e});
    endtask
    task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        int k;
        k = 0;
        do
        begin
            bus(a, 1'b0, 8'h00, 4'h1);
            k++;
        end
        while ((q[7:0] & m) !== v && k < 500);
        if (k == 500)
            fail_stop();
    endtask
    task automatic wait_bits(input int n);
        int k;
        k = 0;
        while (i_serial_node.bits.size() < n && k < 3000)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 3000)
            fail_stop();
    endtask
    function automatic logic [8:0] take(input int n);
        logic [8:0] v;
        v = 9'h000;
        for (int i = 0; i < n; i++)
            v[i] = i_serial_node.bits.pop_front();
        return v;
    endfunction
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            rd(rows[i].a, rows[i].r0);
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r1);
        end
        bus(ADDR_BAUD, 1'b1, 8'hFF, 4'h0);
        rd(ADDR_BAUD, 8'h04);
        check(rx_irq_priority, 1'b0);
        wr(ADDR_ENABLE_BANK, 8'h20);
        wr(ADDR_RX_STATUS, 8'hD8);
        i_serial_node.send(9'h055, 9, 1'b1);
        rd(ADDR_FLAG_BANK, 8'h00);
        i_serial_node.send(9'h13C, 9, 1'b1);
        check(irq, 1'b1);
        rd(ADDR_RX_STATUS, 8'hD9);
        rd(ADDR_RX_DATA, 8'h3C);
        wr(ADDR_ENABLE_BANK, 8'h00);
        wr(ADDR_RX_STATUS, 8'hD0);
        i_serial_node.send(9'h081, 9, 1'b1);
        rd(ADDR_FLAG_BANK, 8'h20);
        check(irq, 1'b0);
        rd(ADDR_RX_DATA, 8'h81);
        i_serial_node.send(9'h011, 9, 1'b1);
        i_serial_node.send(9'h022, 9, 1'b1);
        rd(ADDR_RX_STATUS, 8'hD2);
        wr(ADDR_RX_STATUS, 8'hC0);
        rd(ADDR_RX_STATUS, 8'hC0);
        rd(ADDR_RX_DATA, 8'h11);
        wr(ADDR_RX_STATUS, 8'h90);
        i_serial_node.send(9'h0F0, 8, 1'b0);
        rd(ADDR_RX_STATUS, 8'h94);
        rd(ADDR_RX_DATA, 8'hF0);
        wr(ADDR_RX_STATUS, 8'h80);
        wr(ADDR_TX_STATUS, 8'hB0);
        repeat (2) @(negedge clk);
        check({sck_oe, sdo_oe}, 2'b11);
        rd(ADDR_FLAG_BANK, 8'h10);
        wr(ADDR_FLAG_BANK, 8'h00);
        rd(ADDR_FLAG_BANK, 8'h10);
        wr(ADDR_ENABLE_BANK, 8'h10);
        repeat (2) @(negedge clk);
        check(irq, 1'b1);
        wr(ADDR_ENABLE_BANK, 8'h00);
        rd(ADDR_FLAG_BANK, 8'h10);
        i_serial_node.bits.delete();
        wr(ADDR_TX_DATA, 8'hA5);
        repeat (8) @(posedge clk);
        wr(ADDR_TX_DATA, 8'h5A);
        rd(ADDR_FLAG_BANK, 8'h10);
        rd(ADDR_TX_STATUS, 8'hB0);
        // The flag only takes its new value two instruction cycles after the write.
        repeat (4) @(posedge clk);
        rd(ADDR_FLAG_BANK, 8'h00);
        rd(ADDR_TX_DATA, 8'h5A);
        wait_bits(16);
        check(take(8), 9'h0A5);
        check(take(8), 9'h05A);
        poll(ADDR_TX_STATUS, 8'h02, 8'h02);
        rd(ADDR_FLAG_BANK, 8'h10);
        wr(ADDR_TX_STATUS, 8'hF1);
        wr(ADDR_RX_STATUS, 8'h90);
        wr(ADDR_TX_DATA, 8'h33);
        repeat (100) @(posedge clk);
        check(i_serial_node.bits.size(), 0);
        wr(ADDR_RX_STATUS, 8'h80);
        wait_bits(9);
        check(take(9), 9'h133);
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk);
        check({irq, rx_irq_priority, sck_oe, sdo_oe, sdo}, 5'b01001);
        rd(ADDR_TX_STATUS, TX_STATUS_RESET);
        report_and_stop();
    end
endmodule
